// ### shared/atps_pkg.sv
// Purpose: constants, register map and carrier types of the trigger program select block
// Assumes: 32-bit Avalon-MM slave, word aligned byte addresses
// Notes:   register offsets are placed at one word per select register
package atps_pkg;

    // register file shape
    localparam int          NUM_SEL      = 7;
    localparam int          ADDR_W       = 5;
    localparam int          DATA_W       = 32;
    localparam int          BE_W         = 4;
    localparam int          SRC_W        = 3;

    // byte addresses
    localparam logic [4:0]  SEL_BASE     = 5'h00;
    localparam logic [4:0]  STATUS_ADDR  = 5'h1c;
    localparam int          WORD_SHIFT   = 2;

    // select register fields
    localparam int          ENABLE_BIT   = 7;
    localparam int          PROG_LSB     = 0;
    localparam int          PROG_W       = 3;
    localparam logic [2:0]  PROG_MAX     = 3'h5;
    localparam logic [2:0]  PROG_RESET   = 3'h0;
    localparam logic        ENABLE_RESET = 1'h0;

    // conversion slots of one program, one per result register 0..3
    localparam int          SLOT_W       = 2;
    localparam logic [1:0]  SLOT_FIRST   = 2'h0;
    localparam logic [1:0]  SLOT_LAST    = 2'h3;

    // status register fields
    localparam int          ST_PEND_LSB  = 0;
    localparam int          ST_BUSY_BIT  = 8;
    localparam int          ST_SLOT_LSB  = 9;
    localparam int          ST_PROG_LSB  = 12;
    localparam int          ST_SRC_LSB   = 16;

    localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

    typedef struct packed {
        logic       enable;
        logic [2:0] prog;
    } atps_sel_t;

    // bit i of the packed value is the trigger owned by select register i
    typedef struct packed {
        logic driver_b_start_pulse_0;
        logic driver_a_start_pulse_5;
        logic driver_a_start_pulse_4;
        logic driver_a_start_pulse_3;
        logic driver_a_start_pulse_2;
        logic driver_a_start_pulse_1;
        logic driver_a_start_pulse_0;
    } atps_trig_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] prog;
        logic [2:0] source;
    } atps_launch_t;

    typedef enum logic [1:0] {
        ATPS_IDLE = 2'b01,
        ATPS_SLOT = 2'b10
    } atps_state_t;

endpackage

// ### design/atps_channel.sv
// Purpose: one select register with its trigger gate and pending flag
// Assumes: start pulse comes from logic on clk, one cycle wide
// Notes:   reserved program codes are stored but refuse new triggers; a trigger already waiting launches the code held at grant
`timescale 1ns/1ps
`default_nettype none
module atps_channel
    import atps_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic      start_pulse,
    input  wire logic      grant,
    output var  atps_sel_t sel,
    output var  logic      pending
);

    logic prog_legal;
    logic accept;

    assign prog_legal = (sel.prog <= PROG_MAX);
    assign accept     = start_pulse & sel.enable & prog_legal;

    // only bit 7 and bits 2..0 hold state; bits 6..3 drop on write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel.enable  <= ENABLE_RESET;
            sel.prog    <= PROG_RESET;
        end else if (wr_en) begin
            sel.enable  <= wr_data[ENABLE_BIT];
            sel.prog    <= wr_data[PROG_LSB +: PROG_W];
        end
    end

    // a trigger in the grant cycle is kept; disabling drops a waiting one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else begin
            pending <= accept | (pending & ~grant & sel.enable);
        end
    end

endmodule
`default_nettype wire

// ### design/atps_top.sv
// Purpose: trigger program select registers and launch sequencing for the converter
// Assumes: start pulses and converter strobes are synchronous to clk
// Notes:   one program runs at a time; waiting triggers are served lowest index first
//
// Overview of operation
// - bit 7 enables its trigger; disabled triggers never start a conversion
// - bits 2..0 choose the program that the enabled trigger launches
// - registers 0, 1, 2 own driver a triggers 0, 1, 2
// - register 3 owns driver a trigger 3 only
// - register 4 owns driver a trigger 4 only
// - register 5 owns driver a trigger 5 only
// - register 6 owns driver b trigger 0 only
// - codes 000..101 mean programs 0..5; 110 and 111 are reserved
// - only programs 0 to 5 accept a trigger; a waiting trigger launches whatever code its register holds at grant
// - a program converts up to four slots into result registers 0..3
`timescale 1ns/1ps
`default_nettype none
module atps_top
    import atps_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [BE_W-1:0]   avs_byteenable,
    output var  logic [DATA_W-1:0] avs_readdata,
    output var  logic              avs_waitrequest,
    // trigger inputs from the motor drivers
    input  wire atps_trig_t        start_pulses,
    // converter side
    input  wire logic              conv_slot_done,
    input  wire logic              conv_last_slot,
    output var  atps_launch_t      launch,
    output var  logic              slot_start,
    output var  logic [SLOT_W-1:0] conv_slot,
    output var  logic              result_write,
    output var  logic [SLOT_W-1:0] result_index,
    output var  logic              busy
);

    logic [NUM_SEL-1:0] trig_vec;
    logic [NUM_SEL-1:0] pend;
    logic [NUM_SEL-1:0] grant;
    logic [NUM_SEL-1:0] sel_wr;
    atps_sel_t          sel [NUM_SEL];
    atps_state_t        state;
    atps_state_t        next_state;
    logic [SRC_W-1:0]   grant_idx;
    logic               any_pend;
    logic               req;
    logic               bus_go;
    logic               sel_hit;
    logic [SRC_W-1:0]   word_idx;
    logic [DATA_W-1:0]  next_readdata;
    logic               slot_end;

    // bit i of the vector belongs to select register i
    assign trig_vec = start_pulses;

    // ---------------------------------------------------------------
    // avalon-mm slave
    // ---------------------------------------------------------------
    // waitrequest drops for exactly one cycle per request; the access
    // takes effect at that edge, so every transfer costs two cycles
    assign req      = avs_read | avs_write;
    assign bus_go   = req & ~avs_waitrequest;
    assign word_idx = avs_address[WORD_SHIFT +: SRC_W];
    assign sel_hit  = (avs_address[WORD_SHIFT-1:0] == SEL_BASE[WORD_SHIFT-1:0])
                      && (int'(word_idx) < NUM_SEL);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
        end
    end

    // unmapped and misaligned addresses read zero
    always_comb begin
        next_readdata = READ_ZERO;
        if (sel_hit) begin
            next_readdata[ENABLE_BIT]            = sel[word_idx].enable;
            next_readdata[PROG_LSB +: PROG_W]    = sel[word_idx].prog;
        end else if (avs_address == STATUS_ADDR) begin
            next_readdata[ST_PEND_LSB +: NUM_SEL] = pend;
            next_readdata[ST_BUSY_BIT]            = busy;
            next_readdata[ST_SLOT_LSB +: SLOT_W]  = conv_slot;
            next_readdata[ST_PROG_LSB +: PROG_W]  = launch.prog;
            next_readdata[ST_SRC_LSB +: SRC_W]    = launch.source;
        end
    end

    // data is loaded as waitrequest falls and held until the next answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= READ_ZERO;
        end else if (avs_read & avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    // ---------------------------------------------------------------
    // select registers, one per trigger
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SEL; gi++) begin : g_sel
            // only byte lane 0 carries live bits
            assign sel_wr[gi] = bus_go & avs_write & sel_hit & avs_byteenable[0]
                                & (int'(word_idx) == gi);

            atps_channel u_chan (
                .clk         (clk),
                .rst_n       (rst_n),
                .wr_en       (sel_wr[gi]),
                .wr_data     (avs_writedata[7:0]),
                .start_pulse (trig_vec[gi]),
                .grant       (grant[gi]),
                .sel         (sel[gi]),
                .pending     (pend[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // arbitration
    // ---------------------------------------------------------------
    // fixed priority keeps the logic small; a busy trigger 0 can starve
    // higher numbers only if it fires faster than a program completes
    function automatic logic [SRC_W-1:0] lowest_set(input logic [NUM_SEL-1:0] v);
        logic [SRC_W-1:0] idx;
        idx = '0;
        for (int i = NUM_SEL - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = SRC_W'(i);
            end
        end
        return idx;
    endfunction

    assign any_pend  = |pend;
    assign grant_idx = lowest_set(pend);

    always_comb begin
        grant = '0;
        if ((state == ATPS_IDLE) && any_pend) begin
            grant[grant_idx] = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // program sequencing
    // ---------------------------------------------------------------
    // a program may end early when the converter flags its last slot
    assign slot_end = conv_last_slot | (conv_slot == SLOT_LAST);

    always_comb begin
        next_state = state;
        unique case (state)
            ATPS_IDLE: begin
                if (any_pend) begin
                    next_state = ATPS_SLOT;
                end
            end
            ATPS_SLOT: begin
                if (conv_slot_done && slot_end) begin
                    next_state = ATPS_IDLE;
                end
            end
            default: begin
                next_state = ATPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ATPS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // launch descriptor; valid is a one-cycle pulse, fields stay for status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            launch <= '0;
        end else if (grant != '0) begin
            launch.valid   <= 1'b1;
            launch.prog    <= sel[grant_idx].prog;
            launch.source  <= grant_idx;
        end else begin
            launch.valid   <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (next_state == ATPS_SLOT);
        end
    end

    // slot counter: result register index of the slot in conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_slot <= SLOT_FIRST;
        end else if (grant != '0) begin
            conv_slot <= SLOT_FIRST;
        end else if ((state == ATPS_SLOT) && conv_slot_done && !slot_end) begin
            conv_slot <= conv_slot + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_start <= 1'b0;
        end else begin
            slot_start <= (grant != '0)
                          | ((state == ATPS_SLOT) & conv_slot_done & ~slot_end);
        end
    end

    // result strobe names the result register 0..3 of the finished slot
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_write <= 1'b0;
            result_index <= SLOT_FIRST;
        end else begin
            result_write <= (state == ATPS_SLOT) & conv_slot_done;
            if ((state == ATPS_SLOT) && conv_slot_done) begin
                result_index <= conv_slot;
            end
        end
    end

endmodule
`default_nettype wire

// ### testbench/atps_monitor.sv
// Purpose: checker for select registers and launch sequencing
// Assumes: bound to atps_top, one clock domain
// Notes:   shadows landed writes to know which triggers are armed
`timescale 1ns/1ps
`default_nettype none
module atps_monitor
    import atps_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0]   avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              conv_slot_done,
    input wire logic              conv_last_slot,
    input wire atps_launch_t      launch,
    input wire logic              slot_start,
    input wire logic [SLOT_W-1:0] conv_slot,
    input wire logic              result_write,
    input wire logic [SLOT_W-1:0] result_index,
    input wire logic              busy
);
    logic [6:0] en;
    logic [2:0] pg [7];
    wire        wr   = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire        done = busy && conv_slot_done;
    wire [2:0]  a    = avs_address[4:2];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en <= '0;
            pg <= '{default: 3'h0};
        end else if (wr && a != 3'h7) begin
            en[a] <= avs_writedata[ENABLE_BIT];
            pg[a] <= avs_writedata[2:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_first;
        slot_start && busy && conv_slot == SLOT_FIRST;
    endsequence
    sequence s_next;
        result_write && slot_start && conv_slot == $past(conv_slot) + 2'h1;
    endsequence
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus wait not one cycle");
    a_read_back: assert property (
        avs_read && !avs_waitrequest && a != 3'h7 |-> avs_readdata == {24'h0, en[a], 4'h0, pg[a]})
        else $error("select read data wrong");
    a_launch_armed: assert property (
        launch.valid |-> en[launch.source] && launch.prog == pg[launch.source]
        && launch.prog <= PROG_MAX) else $error("launch not armed");
    a_launch_start: assert property (
        launch.valid |-> !$past(busy) ##0 s_first) else $error("launch start wrong");
    a_slot_step: assert property (
        done && !conv_last_slot && conv_slot != SLOT_LAST |=> s_next) else $error("slot step wrong");
    a_result_index: assert property (
        done |=> result_write && result_index == $past(conv_slot)) else $error("result index wrong");
    a_prog_end: assert property (
        done && (conv_last_slot || conv_slot == SLOT_LAST) |=> !busy && !slot_start)
        else $error("program did not end");
    a_result_cause: assert property (
        result_write |-> $past(done)) else $error("stray result write");
    a_reset_clear: assert property (
        $rose(rst_n) |-> !busy && !launch.valid && avs_waitrequest) else $error("reset state wrong");
endmodule
bind atps_top atps_monitor u_mon (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_slot_done(conv_slot_done),
    .conv_last_slot(conv_last_slot), .launch(launch), .slot_start(slot_start),
    .conv_slot(conv_slot), .result_write(result_write), .result_index(result_index),
    .busy(busy));
`default_nettype wire

// ### testbench/atps_far_model.sv
// Purpose: trigger generator and converter stand-in
// Assumes: bench requests pulses on fire, one cycle each except a four-cycle trigger 0 burst just before reset
// Notes:   last-slot flag is scrambled outside its done pulse
`timescale 1ns/1ps
`default_nettype none
module atps_far_model
    import atps_pkg::*;
#(
    parameter int DLY = 3
)
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [6:0] fire,
    input  wire logic [1:0] last_at,
    input  wire logic       slot_start,
    input  wire logic [1:0] conv_slot,
    output var  atps_trig_t start_pulses,
    output var  logic       conv_slot_done,
    output var  logic       conv_last_slot
);
    int cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_pulses   <= '0;
            cnt            <= 0;
            conv_slot_done <= 1'b0;
            conv_last_slot <= 1'b0;
        end else begin
            start_pulses   <= fire;
            cnt            <= slot_start ? DLY : (cnt > 0 ? cnt - 1 : 0);
            conv_slot_done <= (cnt == 1);
            conv_last_slot <= (cnt == 1) ? (conv_slot == last_at) : !conv_last_slot;
        end
    end
endmodule
`default_nettype wire

// ### testbench/atps_top_bench.sv
// Purpose: self-checking bench for the trigger program select block
// Assumes: far side modelled by atps_far_model
// Notes:   each row writes, reads back and fires one trigger
`timescale 1ns/1ps
`default_nettype none
module atps_top_bench
    import atps_pkg::*;
;
    typedef struct packed {
        logic [2:0]  idx;
        logic [31:0] wd;
        logic [31:0] rd;
        logic        go;
        logic [1:0]  last;
    } atps_row_t;
    // reserved bits set in rows 1, 4 and 7; codes 6 and 7 must not launch
    localparam atps_row_t ROWS [10] = '{
        '{3'h0, 32'h85, 32'h85, 1'b1, 2'h3}, '{3'h1, 32'hffff_ff81, 32'h81, 1'b1, 2'h0},
        '{3'h2, 32'h82, 32'h82, 1'b1, 2'h1}, '{3'h3, 32'h03, 32'h03, 1'b0, 2'h0},
        '{3'h3, 32'hfb, 32'h83, 1'b1, 2'h2}, '{3'h4, 32'h84, 32'h84, 1'b1, 2'h3},
        '{3'h5, 32'h86, 32'h86, 1'b0, 2'h0}, '{3'h5, 32'h8d, 32'h85, 1'b1, 2'h0},
        '{3'h6, 32'h80, 32'h80, 1'b1, 2'h2}, '{3'h6, 32'h87, 32'h87, 1'b0, 2'h0}};
    logic              clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic              slot_start, result_write, busy, conv_slot_done, conv_last_slot, got;
    logic [4:0]        avs_address;
    logic [31:0]       avs_writedata, avs_readdata, q;
    logic [3:0]        avs_byteenable;
    logic [1:0]        conv_slot, result_index, last_at;
    logic [6:0]        fire;
    atps_trig_t        start_pulses;
    atps_launch_t      launch, l;
    int                error_cnt, n_compared, n_res, cycles;
    atps_top u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .start_pulses(start_pulses), .conv_slot_done(conv_slot_done),
        .conv_last_slot(conv_last_slot), .launch(launch), .slot_start(slot_start),
        .conv_slot(conv_slot), .result_write(result_write), .result_index(result_index),
        .busy(busy));
    atps_far_model u_far (.clk(clk), .rst_n(rst_n), .fire(fire), .last_at(last_at),
        .slot_start(slot_start), .conv_slot(conv_slot), .start_pulses(start_pulses),
        .conv_slot_done(conv_slot_done), .conv_last_slot(conv_last_slot));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] adr, input logic [31:0] d);
        avs_write     <= w;
        avs_read      <= !w;
        avs_address   <= adr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask
    // fire edge is also watched: a queued launch may land right there
    task automatic run(input logic [6:0] v);
        got   = 1'b0;
        n_res = 0;
        fire <= v;
        for (int i = 0; i < 9 && !got; i++) begin
            @(posedge clk);
            fire <= '0;
            if (launch.valid === 1'b1) begin
                got = 1'b1;
                l   = launch;
            end
        end
        // results counted here, at the same edge that sees busy drop
        for (int i = 0; i < 200 && busy !== 1'b0; i++) begin
            @(posedge clk);
            if (result_write === 1'b1)
                n_res++;
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        {rst_n, avs_read, avs_write, avs_address, avs_writedata, fire} = '0;
        avs_byteenable = 4'hf;
        last_at        = 2'h3;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (ROWS[r]) begin
            last_at <= ROWS[r].last;
            bus(1'b1, {ROWS[r].idx, 2'b00}, ROWS[r].wd);
            bus(1'b0, {ROWS[r].idx, 2'b00}, 32'h0);
            check("readback", q, ROWS[r].rd);
            run(7'h01 << ROWS[r].idx);
            check("launched", got, ROWS[r].go);
            if (got === 1'b1) begin
                check("source", l.source, ROWS[r].idx);
                check("program", l.prog, ROWS[r].rd[2:0]);
                check("slots", n_res, ROWS[r].last + 1);
            end
            $display("row %0d done", r);
        end
        // a write with lane 0 off must leave register 0 as it was
        avs_byteenable <= 4'he;
        bus(1'b1, 5'h00, 32'h0);
        avs_byteenable <= 4'hf;
        bus(1'b0, 5'h00, 32'h0);
        check("lane 0 off", q, 32'h85);
        $display("lane test done");
        last_at <= 2'h3;
        run(7'h12);
        check("first source", l.source, 3'h1);
        run(7'h00);
        check("second source", l.source, 3'h4);
        check("second program", l.prog, 3'h4);
        $display("simultaneous triggers done");
        fire <= 7'h01;
        repeat (4) @(posedge clk);
        fire  <= '0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("busy after reset", busy, 1'b0);
        for (int i = 0; i < NUM_SEL; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            check("reset value", q, 32'h0);
        end
        run(7'h7f);
        check("launch after reset", got, 1'b0);
        $display("reset test done");
        results();
    end
endmodule
`default_nettype wire
